// file: core/bflvs_pkg.sv
package bflvs_pkg;
    // =========================================================
    // register map
    localparam logic [5:0] SR2_ADDR       = 6'h06;
    localparam logic [5:0] SR3_ADDR       = 6'h07;
    localparam int         FRAME_W        = 24;
    // =========================================================
    // field positions
    localparam int         FB_FAULT_BIT   = 6;
    localparam int         DIN_STATE_BIT  = 5;
    localparam int         WD_PROG_LSB    = 15;
    localparam int         PARITY_BIT     = 0;
    localparam int         STR1_LSB       = 16;
    localparam int         STR2_LSB       = 8;
    // =========================================================
    // reset values
    localparam logic [7:0] VOLT_RST       = 8'h00;
    localparam logic [1:0] WD_PROG_RST    = 2'h0;
    // =========================================================
    // watchdog progress thresholds in percent
    localparam logic [6:0] WD_PCT_Q1      = 7'h18;
    localparam logic [6:0] WD_PCT_Q2      = 7'h32;
    localparam logic [6:0] WD_PCT_Q3      = 7'h4A;
    // =========================================================
    // timing
    localparam int         CLK_MHZ        = 250;
    localparam int         FILTER_TIME_US = 20;
    localparam int         RESTART_TIME_MS = 10;
    localparam int         FILTER_CYCLES  = FILTER_TIME_US * CLK_MHZ;
    localparam int         RESTART_CYCLES = RESTART_TIME_MS * 1000 * CLK_MHZ;
    localparam int         SYNC_HALF_CYCLES = 4;
endpackage : bflvs_pkg

// file: core/bflvs_input_filter.sv
`timescale 1ns/10ps
// =========================================================
// debounce: output follows input once it held steady long enough
module bflvs_input_filter #(
    parameter int FILTER_CYCLES = 5000
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic raw_in,
    output logic      filtered
);
    localparam int CW = $clog2(FILTER_CYCLES + 1);
    logic [CW-1:0] stable_count;

    // count cycles in which the raw level differs from the reported one
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stable_count <= '0;
            filtered     <= 1'b0;
        end else if (raw_in == filtered) begin
            stable_count <= '0;
        end else if (stable_count == CW'(FILTER_CYCLES - 1)) begin
            stable_count <= '0;
            filtered     <= raw_in;
        end else begin
            stable_count <= stable_count + 1'b1;
        end
    end
endmodule : bflvs_input_filter

// file: core/bflvs_status_bank.sv
`timescale 1ns/10ps
// What this block does
// - feedback short to ground sets fault bit 6
// - fault blocks boost start, stops running boost
// - fault stops all sync clock output
// - fault in limp home pulls compensation low
// - boost disabled means fault never sets
// - boost stays off until acknowledged read-clear
// - limp home auto restart clears fault periodically
// - bit 5 reports filtered direct input level
// - bit 0 makes every frame odd parity
// - bits 23:16 hold string1 off-time voltage
// - bits 15:8 hold string2 off-time voltage
// - direct or serial control refreshes every cycle the buck is off
// - dimming control refreshes once before off end
// - bits 16:15 report watchdog progress
// - watchdog fault in active mode enters limp home
module bflvs_status_bank #(
    parameter int FILTER_CYCLES  = bflvs_pkg::FILTER_CYCLES,
    parameter int RESTART_CYCLES = bflvs_pkg::RESTART_CYCLES
) (
    input  wire logic       CLK_SYS,
    input  wire logic       RST_B,
    input  wire logic       FEEDBACK_SENSE_SHORT,
    input  wire logic       BOOST_DISABLE,
    input  wire logic       BOOST_START_REQ,
    input  wire logic       WATCHDOG_FAULT,
    input  wire logic       LIMP_HOME_EXIT,
    input  wire logic [6:0] WATCHDOG_ELAPSED_PCT,
    input  wire logic       DIRECT_INPUT,
    input  wire logic [7:0] STRING1_ADC,
    input  wire logic [7:0] STRING2_ADC,
    input  wire logic       BUCK1_ON,
    input  wire logic       BUCK2_ON,
    input  wire logic       BUCK1_DIMMING_MODE,
    input  wire logic       BUCK2_DIMMING_MODE,
    input  wire logic       BUCK1_OFF_END,
    input  wire logic       BUCK2_OFF_END,
    input  wire logic       REG_READ,
    input  wire logic       REG_CLEAR,
    input  wire logic [5:0] REG_ADDR,
    output logic [23:0]     REG_RDATA,
    output logic            BOOST_ENABLE,
    output logic            SYNC_CLK_OUT,
    output logic            COMP_PULL_DOWN,
    output logic            LIMP_HOME_MODE,
    output logic            BOOST_FEEDBACK_FAULT
);
    // =========================================================
    // helpers
    function automatic logic [23:0] with_parity(input logic [23:0] frame);
        with_parity    = frame;
        with_parity[0] = ~^frame[23:1];
    endfunction : with_parity

    function automatic logic [1:0] wd_encode(input logic [6:0] pct);
        if (pct < bflvs_pkg::WD_PCT_Q1)      wd_encode = 2'h0;
        else if (pct < bflvs_pkg::WD_PCT_Q2) wd_encode = 2'h1;
        else if (pct < bflvs_pkg::WD_PCT_Q3) wd_encode = 2'h2;
        else                                 wd_encode = 2'h3;
    endfunction : wd_encode

    // =========================================================
    // declarations
    localparam int RW = $clog2(RESTART_CYCLES + 1);
    localparam int SW = $clog2(bflvs_pkg::SYNC_HALF_CYCLES + 1);
    logic          limp_home;
    logic          fb_fault;
    logic [RW-1:0] restart_count;
    logic          restart_tick;
    logic [SW-1:0] sync_count;
    logic          sync_clk;
    logic          din_state;
    logic [7:0]    string1_offtime_voltage;
    logic [7:0]    string2_offtime_voltage;
    logic [1:0]    watchdog_progress;
    logic          clr_sr2;
    logic          clr_sr3;
    logic          upd1;
    logic          upd2;
    logic [23:0]   next_frame;

    assign clr_sr2 = REG_READ && REG_CLEAR && (REG_ADDR == bflvs_pkg::SR2_ADDR);
    assign clr_sr3 = REG_READ && REG_CLEAR && (REG_ADDR == bflvs_pkg::SR3_ADDR);

    // =========================================================
    // limp home: entered on watchdog fault, left on external request
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            limp_home <= 1'b0;
        end else if (WATCHDOG_FAULT) begin
            limp_home <= 1'b1;
        end else if (LIMP_HOME_EXIT) begin
            limp_home <= 1'b0;
        end
    end

    // =========================================================
    // auto restart timer only runs in limp home
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            restart_count <= '0;
        end else if (!limp_home || restart_tick) begin
            restart_count <= '0;
        end else begin
            restart_count <= restart_count + 1'b1;
        end
    end
    assign restart_tick = limp_home && (restart_count == RW'(RESTART_CYCLES - 1));

    // =========================================================
    // feedback fault: a detected short wins over a clear in the same cycle
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            fb_fault <= 1'b0;
        end else if (FEEDBACK_SENSE_SHORT && !BOOST_DISABLE) begin
            fb_fault <= 1'b1;
        end else if (clr_sr2 || restart_tick) begin
            fb_fault <= 1'b0;
        end
    end

    // boost gating is combinational so a running boost stops at once
    assign BOOST_ENABLE   = BOOST_START_REQ && !BOOST_DISABLE && !fb_fault;
    assign COMP_PULL_DOWN = fb_fault && limp_home;
    assign LIMP_HOME_MODE = limp_home;
    assign BOOST_FEEDBACK_FAULT = fb_fault;

    // =========================================================
    // sync clock divider, held low while the fault stands
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            sync_count <= '0;
            sync_clk   <= 1'b0;
        end else if (fb_fault || !BOOST_ENABLE) begin
            sync_count <= '0;
            sync_clk   <= 1'b0;
        end else if (sync_count == SW'(bflvs_pkg::SYNC_HALF_CYCLES - 1)) begin
            sync_count <= '0;
            sync_clk   <= ~sync_clk;
        end else begin
            sync_count <= sync_count + 1'b1;
        end
    end
    assign SYNC_CLK_OUT = sync_clk;

    // =========================================================
    // direct input filter
    bflvs_input_filter #(
        .FILTER_CYCLES(FILTER_CYCLES)
    ) u_din_filter (
        .clk     (CLK_SYS),
        .rst_b   (RST_B),
        .raw_in  (DIRECT_INPUT),
        .filtered(din_state)
    );

    // =========================================================
    // watchdog progress, registered to keep the read frame glitch free
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            watchdog_progress <= bflvs_pkg::WD_PROG_RST;
        end else begin
            watchdog_progress <= wd_encode(WATCHDOG_ELAPSED_PCT);
        end
    end

    // =========================================================
    // off-time voltage capture; a fresh sample wins over read-clear
    assign upd1 = BUCK1_DIMMING_MODE ? BUCK1_OFF_END : !BUCK1_ON;
    assign upd2 = BUCK2_DIMMING_MODE ? BUCK2_OFF_END : !BUCK2_ON;

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            string1_offtime_voltage <= bflvs_pkg::VOLT_RST;
        end else if (upd1) begin
            string1_offtime_voltage <= STRING1_ADC;
        end else if (clr_sr3) begin
            string1_offtime_voltage <= bflvs_pkg::VOLT_RST;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            string2_offtime_voltage <= bflvs_pkg::VOLT_RST;
        end else if (upd2) begin
            string2_offtime_voltage <= STRING2_ADC;
        end else if (clr_sr3) begin
            string2_offtime_voltage <= bflvs_pkg::VOLT_RST;
        end
    end

    // =========================================================
    // read frame assembly; unused positions stay zero
    always_comb begin
        next_frame = '0;
        case (REG_ADDR)
            bflvs_pkg::SR2_ADDR: begin
                next_frame[bflvs_pkg::WD_PROG_LSB +: 2]  = watchdog_progress;
                next_frame[bflvs_pkg::FB_FAULT_BIT]      = fb_fault;
                next_frame[bflvs_pkg::DIN_STATE_BIT]     = din_state;
            end
            bflvs_pkg::SR3_ADDR: begin
                next_frame[bflvs_pkg::STR1_LSB +: 8] = string1_offtime_voltage;
                next_frame[bflvs_pkg::STR2_LSB +: 8] = string2_offtime_voltage;
            end
            default: begin
                next_frame = '0;
            end
        endcase
    end

    // frame captured at the read so a same-cycle clear never hides the value
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            REG_RDATA <= '0;
        end else if (REG_READ) begin
            REG_RDATA <= with_parity(next_frame);
        end
    end
endmodule : bflvs_status_bank

// file: dv/bflvs_props.sv
`timescale 1ns/10ps
// =========================================================
// port checker for the status bank
module bflvs_props #(
    parameter int FILTER_CYCLES  = 4,
    parameter int RESTART_CYCLES = 20
) (
    input wire logic        CLK_SYS,
    input wire logic        RST_B,
    input wire logic        FEEDBACK_SENSE_SHORT,
    input wire logic        BOOST_DISABLE,
    input wire logic        WATCHDOG_FAULT,
    input wire logic        REG_READ,
    input wire logic        REG_CLEAR,
    input wire logic [5:0]  REG_ADDR,
    input wire logic [23:0] REG_RDATA,
    input wire logic        BOOST_ENABLE,
    input wire logic        SYNC_CLK_OUT,
    input wire logic        COMP_PULL_DOWN,
    input wire logic        LIMP_HOME_MODE,
    input wire logic        BOOST_FEEDBACK_FAULT
);
    logic [31:0] stuck;
    // cycles a limp home fault survives with the short gone; a count keeps the bound exact
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) stuck <= 32'h0;
        else if (BOOST_FEEDBACK_FAULT && LIMP_HOME_MODE && !FEEDBACK_SENSE_SHORT) stuck <= stuck + 32'h1;
        else stuck <= 32'h0;
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    fault_set_a: assert property (
        FEEDBACK_SENSE_SHORT && !BOOST_DISABLE |=> BOOST_FEEDBACK_FAULT) else $error("short not flagged");
    no_set_dis_a: assert property (
        BOOST_DISABLE && !BOOST_FEEDBACK_FAULT |=> !BOOST_FEEDBACK_FAULT) else $error("set while disabled");
    boost_block_a: assert property (
        BOOST_FEEDBACK_FAULT |-> !BOOST_ENABLE) else $error("boost on with fault");
    sync_stop_a: assert property (
        BOOST_FEEDBACK_FAULT |=> !SYNC_CLK_OUT) else $error("sync runs with fault");
    comp_low_a: assert property (
        COMP_PULL_DOWN == (BOOST_FEEDBACK_FAULT && LIMP_HOME_MODE)) else $error("comp pull wrong");
    fault_hold_a: assert property (
        BOOST_FEEDBACK_FAULT && !LIMP_HOME_MODE && !WATCHDOG_FAULT
        && !(REG_READ && REG_CLEAR && REG_ADDR == bflvs_pkg::SR2_ADDR)
        |=> BOOST_FEEDBACK_FAULT) else $error("fault lost without clear");
    restart_a: assert property (
        stuck <= RESTART_CYCLES + 1) else $error("restart too late");
    limp_enter_a: assert property (
        WATCHDOG_FAULT |=> LIMP_HOME_MODE) else $error("no limp home");
    odd_frame_a: assert property (
        REG_READ |=> ^REG_RDATA) else $error("even parity frame");
    unmapped_zero_a: assert property (
        REG_READ && REG_ADDR != bflvs_pkg::SR2_ADDR && REG_ADDR != bflvs_pkg::SR3_ADDR
        |=> REG_RDATA == 24'h000001) else $error("unmapped read not zero");
    cover property (BOOST_FEEDBACK_FAULT && LIMP_HOME_MODE);
    cover property ($fell(BOOST_FEEDBACK_FAULT));
    cover property (REG_READ && REG_CLEAR);
endmodule : bflvs_props

bind bflvs_status_bank bflvs_props #(
    .FILTER_CYCLES(FILTER_CYCLES),
    .RESTART_CYCLES(RESTART_CYCLES)
) i_bflvs_props (.*);

// file: dv/bflvs_host_model.sv
`timescale 1ns/10ps
// =========================================================
// host master issuing status reads
module bflvs_host_model (
    input  wire logic        clk,
    input  wire logic [23:0] rdata,
    output logic             read,
    output logic             clear,
    output logic [5:0]       addr
);
    initial begin
        read  = 1'b0;
        clear = 1'b0;
        addr  = 6'h3F;
    end
    // address scrambled after release so nothing leans on a stale value
    task automatic rd(input logic [5:0] a, input logic c, output logic [23:0] d);
        @(posedge clk);
        read  <= 1'b1;
        clear <= c;
        addr  <= a;
        @(posedge clk);
        read  <= 1'b0;
        clear <= 1'b0;
        addr  <= ~a;
        @(posedge clk);
        d = rdata;
    endtask : rd
endmodule : bflvs_host_model

// file: dv/tb_boost_fault_led_voltage_status.sv
`timescale 1ns/10ps
// =========================================================
// bench for the status bank
module tb_boost_fault_led_voltage_status;
    typedef struct packed {
        logic [5:0]  addr;
        logic [6:0]  pct;
        logic [5:0]  ctl; // on1 dim1 end1 on2 dim2 end2
        logic [7:0]  a1;
        logic [7:0]  a2;
        logic [23:0] exp; // parity added by the loop
    } bflvs_row_type;
    bflvs_row_type rows [13];
    logic clk = 1'b0, rst_b = 1'b0, fb_short = 1'b0, boost_disable = 1'b0, start_req = 1'b1;
    logic wd_fault = 1'b0, lh_exit = 1'b0, din = 1'b0, on1 = 1'b0, on2 = 1'b0;
    logic dim1 = 1'b0, dim2 = 1'b0, end1 = 1'b0, end2 = 1'b0, rd, clr;
    logic [6:0]  wd_pct = 7'h00;
    logic [7:0]  adc1 = 8'h00, adc2 = 8'h00;
    logic [5:0]  addr;
    logic [23:0] rdata, d;
    logic        bst_en, sync, comp, limp, fault;
    int          err_count = 0, check_count = 0, n;
    always #2 clk = ~clk;
    bflvs_status_bank #(.FILTER_CYCLES(4), .RESTART_CYCLES(20)) i_bflvs_status_bank (
        .CLK_SYS(clk), .RST_B(rst_b), .FEEDBACK_SENSE_SHORT(fb_short), .BOOST_DISABLE(boost_disable),
        .BOOST_START_REQ(start_req), .WATCHDOG_FAULT(wd_fault), .LIMP_HOME_EXIT(lh_exit),
        .WATCHDOG_ELAPSED_PCT(wd_pct), .DIRECT_INPUT(din), .STRING1_ADC(adc1),
        .STRING2_ADC(adc2), .BUCK1_ON(on1), .BUCK2_ON(on2), .BUCK1_DIMMING_MODE(dim1),
        .BUCK2_DIMMING_MODE(dim2), .BUCK1_OFF_END(end1), .BUCK2_OFF_END(end2), .REG_READ(rd),
        .REG_CLEAR(clr), .REG_ADDR(addr), .REG_RDATA(rdata), .BOOST_ENABLE(bst_en),
        .SYNC_CLK_OUT(sync), .COMP_PULL_DOWN(comp), .LIMP_HOME_MODE(limp),
        .BOOST_FEEDBACK_FAULT(fault));
    bflvs_host_model i_bflvs_host_model (
        .clk(clk), .rdata(rdata), .read(rd), .clear(clr), .addr(addr));
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    // hang guard; a spent limit counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        finish_test();
    end
    initial begin
        rows = '{'{6'h06, 7'h00, 6'h00, 8'h00, 8'h00, 24'h000000},
                 '{6'h06, 7'h17, 6'h00, 8'h00, 8'h00, 24'h000000},
                 '{6'h06, 7'h18, 6'h00, 8'h00, 8'h00, 24'h008000},
                 '{6'h06, 7'h31, 6'h00, 8'h00, 8'h00, 24'h008000},
                 '{6'h06, 7'h32, 6'h00, 8'h00, 8'h00, 24'h010000},
                 '{6'h06, 7'h49, 6'h00, 8'h00, 8'h00, 24'h010000},
                 '{6'h06, 7'h4A, 6'h00, 8'h00, 8'h00, 24'h018000},
                 '{6'h06, 7'h64, 6'h00, 8'h00, 8'h00, 24'h018000},
                 '{6'h07, 7'h00, 6'h00, 8'h5A, 8'hA5, 24'h5AA500},
                 '{6'h07, 7'h00, 6'h24, 8'h33, 8'h44, 24'h5AA500},
                 '{6'h07, 7'h00, 6'h12, 8'h77, 8'h88, 24'h5AA500},
                 '{6'h07, 7'h00, 6'h1B, 8'h77, 8'h88, 24'h778800},
                 '{6'h3F, 7'h00, 6'h1B, 8'h77, 8'h88, 24'h000000}};
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        i_bflvs_host_model.rd(6'h06, 1'b0, d);
        chk(d, 24'h000001);
        i_bflvs_host_model.rd(6'h07, 1'b0, d);
        chk(d, 24'h000001);
        // table rows: progress codes, refresh modes, unmapped read
        foreach (rows[i]) begin
            @(posedge clk);
            wd_pct <= rows[i].pct;
            {on1, dim1, end1, on2, dim2, end2} <= rows[i].ctl;
            adc1 <= rows[i].a1;
            adc2 <= rows[i].a2;
            @(posedge clk);
            end1 <= 1'b0;
            end2 <= 1'b0;
            i_bflvs_host_model.rd(rows[i].addr, 1'b0, d);
            chk(d, {rows[i].exp[23:1], ~^rows[i].exp[23:1]});
        end
        $display("test table done");
        // feedback short with boost running
        for (n = 0; n < 16 && sync !== 1'b1; n++) @(posedge clk);
        if (n == 16) begin
            err_count++;
            finish_test();
        end
        @(posedge clk) fb_short <= 1'b1;
        @(posedge clk) fb_short <= 1'b0;
        @(posedge clk) #1;
        chk(24'({fault, bst_en}), 24'h2);
        repeat (20) @(posedge clk);
        #1 chk(24'({fault, sync}), 24'h2);
        i_bflvs_host_model.rd(6'h06, 1'b1, d);
        chk(d, 24'h000040);
        #1 chk(24'({fault, bst_en}), 24'h1);
        $display("test fault done");
        // disabled boost ignores the short
        @(posedge clk);
        boost_disable <= 1'b1;
        fb_short <= 1'b1;
        repeat (4) @(posedge clk);
        #1 chk(24'({fault, bst_en}), 24'h0);
        @(posedge clk);
        boost_disable <= 1'b0;
        fb_short <= 1'b0;
        // limp home entry, comp pull and auto restart
        @(posedge clk) wd_fault <= 1'b1;
        @(posedge clk) wd_fault <= 1'b0;
        fb_short <= 1'b1;
        @(posedge clk) fb_short <= 1'b0;
        @(posedge clk) #1;
        chk(24'({limp, fault, comp}), 24'h7);
        for (n = 0; n < 40 && fault === 1'b1; n++) @(posedge clk);
        if (n == 40) begin
            err_count++;
            finish_test();
        end
        #1 chk(24'({fault, comp}), 24'h0);
        @(posedge clk) lh_exit <= 1'b1;
        @(posedge clk) lh_exit <= 1'b0;
        $display("test limp done");
        // input glitch shorter than the filter, then a steady level
        @(posedge clk) din <= 1'b1;
        @(posedge clk) din <= 1'b0;
        repeat (10) @(posedge clk);
        i_bflvs_host_model.rd(6'h06, 1'b0, d);
        chk(d, 24'h000001);
        din <= 1'b1;
        repeat (10) @(posedge clk);
        i_bflvs_host_model.rd(6'h06, 1'b0, d);
        chk(d, 24'h000020);
        // read and clear of the voltage register
        i_bflvs_host_model.rd(6'h07, 1'b1, d);
        chk(d, 24'h778801);
        i_bflvs_host_model.rd(6'h07, 1'b0, d);
        chk(d, 24'h000001);
        $display("test input and clear done");
        finish_test();
    end
endmodule : tb_boost_fault_led_voltage_status
